/* File: mac_frame_status_hash.sv */
// frame status word builder, missed frame counter and multicast hash
`timescale 1ns/10ps

module mac_frame_status_hash
    import mac_status_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic rx_done,
    input wire rx_result_s rx_result,
    input wire logic tx_done,
    input wire tx_result_s tx_result,
    input wire logic [31:0] tx_control_word,
    input wire logic rx_no_buffer,
    input wire logic hash_start,
    input wire logic [47:0] hash_addr,
    output logic rx_status_valid,
    output logic [31:0] rx_status_word,
    output logic tx_status_valid,
    output logic [31:0] tx_status_word,
    output logic hash_valid,
    output logic [8:0] hash_index,
    output logic irq
);

    typedef struct packed {
        logic [31:0] rdata;
        logic rx_valid;
        logic [31:0] rx_word;
        logic tx_valid;
        logic [31:0] tx_word;
        logic [15:0] missed;
        logic prev_nocar;
        logic [2:0] irq_status;
        logic [2:0] irq_enable;
        logic irq;
        logic [11:0] tx_bytes;
        hash_state_e hstate;
        logic [31:0] crc;
        logic [5:0] bit_cnt;
        logic [47:0] shift;
        logic hvalid;
        logic [8:0] hindex;
    } state_s;

    state_s state_reg;
    state_s state_next;
    reg_req_s req;

    // one lsb-first crc step
    function automatic logic [31:0] crc_step(input logic [31:0] c,
                                             input logic d);
        crc_step = (c >> 1) ^ (((c[0] ^ d)) ? CRC_POLY : 32'h00000000);
    endfunction

    function automatic logic [8:0] hash_of(input logic [31:0] c);
        logic [8:0] h;
        h = '0;
        for (int i = 0; i < HASH_BITS; i++)
        begin
            h[i] = c[31 - i];
        end
        hash_of = h;
    endfunction

    always_comb
    begin
        logic [2:0] events;
        logic [2:0] st;
        events = 3'h0;
        req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
        state_next = state_reg;
        state_next.rx_valid = 1'b0;
        state_next.tx_valid = 1'b0;
        state_next.hvalid = 1'b0;
        state_next.rdata = 32'h00000000;

        // words are built only on the completion strobe
        if (rx_done)
        begin
            state_next.rx_valid = 1'b1;
            state_next.rx_word = 32'h00000000;
            state_next.rx_word[RX_LEN_MSB:RX_LEN_LSB] = rx_result.length;
            state_next.rx_word[RX_MCAST_BIT] = rx_result.multicast;
            state_next.rx_word[RX_LONG_BIT] = rx_result.too_long;
            state_next.rx_word[RX_DRIBBLE_BIT] = rx_result.dribble;
            state_next.rx_word[RX_CRC_BIT] = rx_result.crc_error;
            state_next.rx_word[RX_OVERRUN_BIT] = rx_result.overrun;
            events[IRQ_RX_DONE] = 1'b1;
        end
        if (tx_done)
        begin
            state_next.tx_valid = 1'b1;
            state_next.tx_word = 32'h00000000;
            state_next.tx_word[TX_CARLOSS_BIT] = tx_result.carrier_lost;
            state_next.tx_word[TX_LATECOL_BIT] = tx_result.late_collision;
            state_next.tx_word[TX_NOCAR_BIT] = tx_result.no_carrier;
            state_next.tx_word[TX_EXCOL_BIT] = tx_result.excess_collisions;
            state_next.tx_word[TX_HBFAIL_BIT] = tx_result.heartbeat_fail;
            state_next.tx_word[TX_COLCNT_MSB:TX_COLCNT_LSB] =
                tx_result.collisions;
            state_next.tx_word[TX_DEFER_BIT] = tx_result.deferred;
            // two no-carrier frames in a row flag a shorted cable
            if (tx_result.no_carrier && state_reg.prev_nocar)
            begin
                events[IRQ_SHORT] = 1'b1;
            end
            state_next.prev_nocar = tx_result.no_carrier;
            state_next.tx_bytes =
                12'(tx_control_word[TX_BUF1_MSB:TX_BUF1_LSB]) +
                12'(tx_control_word[TX_BUF2_MSB:TX_BUF2_LSB]);
            events[IRQ_TX_DONE] = 1'b1;
        end

        // saturates rather than wraps would hide the overflow; wrap as 16 bits
        if (rx_no_buffer)
        begin
            state_next.missed = state_reg.missed + 16'h0001;
        end

        case (state_reg.hstate)
            HASH_IDLE:
            begin
                if (hash_start)
                begin
                    state_next.crc = CRC_INIT;
                    state_next.shift = hash_addr;
                    state_next.bit_cnt = 6'h00;
                    state_next.hstate = HASH_RUN;
                end
            end
            HASH_RUN:
            begin
                // byte 0 sits in the low bits, each byte lsb first
                state_next.crc = crc_step(state_reg.crc, state_reg.shift[0]);
                state_next.shift = state_reg.shift >> 1;
                state_next.bit_cnt = state_reg.bit_cnt + 6'h01;
                if (state_reg.bit_cnt == 6'(HASH_BYTES * 8 - 1))
                begin
                    state_next.hstate = HASH_DONE;
                end
            end
            HASH_DONE:
            begin
                state_next.hvalid = 1'b1;
                state_next.hindex = hash_of(state_reg.crc);
                state_next.hstate = HASH_IDLE;
            end
            default:
            begin
                state_next.hstate = HASH_IDLE;
            end
        endcase

        st = state_reg.irq_status;
        if (req.wr && req.addr == OFS_IRQ_CLEAR)
        begin
            st = st & ~req.wdata[2:0];
        end
        if (req.wr && req.addr == OFS_IRQ_ENABLE)
        begin
            state_next.irq_enable = req.wdata[2:0];
        end
        // a new event beats a clear in the same cycle
        state_next.irq_status = st | events;
        state_next.irq = |(state_next.irq_status & state_next.irq_enable);

        if (req.rd)
        begin
            case (req.addr)
                OFS_MISSED: state_next.rdata = {16'h0000, state_reg.missed};
                OFS_HASH: state_next.rdata = {23'h000000, state_reg.hindex};
                OFS_IRQ_STATUS: state_next.rdata = {29'h0, state_reg.irq_status};
                OFS_IRQ_ENABLE: state_next.rdata = {29'h0, state_reg.irq_enable};
                OFS_TX_BYTES: state_next.rdata = {20'h00000, state_reg.tx_bytes};
                default: state_next.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= '0;
            state_reg.missed <= MISSED_RESET;
            state_reg.irq_status <= IRQ_RESET;
            state_reg.irq_enable <= IRQ_RESET;
            state_reg.hstate <= HASH_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata = state_reg.rdata;
    assign rx_status_valid = state_reg.rx_valid;
    assign rx_status_word = state_reg.rx_word;
    assign tx_status_valid = state_reg.tx_valid;
    assign tx_status_word = state_reg.tx_word;
    assign hash_valid = state_reg.hvalid;
    assign hash_index = state_reg.hindex;
    assign irq = state_reg.irq;

    rx_len_a: assert property (@(posedge core_clk) disable iff (reset)
        rx_done |=> rx_status_valid &&
            rx_status_word[29:16] == $past(rx_result.length))
        else $error("rx length field wrong");
    rx_flags_a: assert property (@(posedge core_clk) disable iff (reset)
        rx_done |=> rx_status_word[2:0] == {$past(rx_result.dribble),
            $past(rx_result.crc_error), $past(rx_result.overrun)})
        else $error("rx error bits wrong");
    rx_mcast_a: assert property (@(posedge core_clk) disable iff (reset)
        rx_done |=> rx_status_word[10] == $past(rx_result.multicast) &&
            rx_status_word[7] == $past(rx_result.too_long))
        else $error("rx multicast or long bit wrong");
    tx_colcnt_a: assert property (@(posedge core_clk) disable iff (reset)
        tx_done |=> tx_status_word[6:3] == $past(tx_result.collisions) &&
            tx_status_word[0] == $past(tx_result.deferred))
        else $error("tx collision count wrong");
    tx_faults_a: assert property (@(posedge core_clk) disable iff (reset)
        tx_done |=> tx_status_word[11:7] == {$past(tx_result.carrier_lost),
            $past(tx_result.no_carrier), $past(tx_result.late_collision),
            $past(tx_result.excess_collisions),
            $past(tx_result.heartbeat_fail)})
        else $error("tx fault bits wrong");
    status_timing_a: assert property (@(posedge core_clk) disable iff (reset)
        tx_status_valid |-> $past(tx_done))
        else $error("tx status without completion");
    missed_count_a: assert property (@(posedge core_clk) disable iff (reset)
        rx_no_buffer |=> state_reg.missed == $past(state_reg.missed) + 16'h0001)
        else $error("missed counter did not step");
    hash_len_a: assert property (@(posedge core_clk) disable iff (reset)
        (state_reg.hstate == HASH_IDLE && hash_start) |-> ##50 hash_valid)
        else $error("hash not ready after six bytes");
    hash_order_a: assert property (@(posedge core_clk) disable iff (reset)
        state_reg.hstate == HASH_DONE |=> hash_index[0] == $past(state_reg.crc[31])
            && hash_index[8] == $past(state_reg.crc[23]))
        else $error("hash index order wrong");
    crc_init_a: assert property (@(posedge core_clk) disable iff (reset)
        (state_reg.hstate == HASH_IDLE && hash_start) |=> state_reg.crc == CRC_INIT)
        else $error("crc not preset to all ones");
    short_flag_a: assert property (@(posedge core_clk) disable iff (reset)
        (tx_done && tx_result.no_carrier && state_reg.prev_nocar) |=>
            state_reg.irq_status[IRQ_SHORT])
        else $error("short circuit flag missed");
    buf_sum_a: assert property (@(posedge core_clk) disable iff (reset)
        tx_done |=> state_reg.tx_bytes == 12'($past(tx_control_word[10:0])) +
            12'($past(tx_control_word[21:11])))
        else $error("buffer byte sum wrong");
endmodule

/* File: mac_status_pkg.sv */
// constants and carrier types for the frame status and hash block
package mac_status_pkg;
    // register offsets on the plain register port
    localparam logic [3:0] OFS_MISSED = 4'h0;
    localparam logic [3:0] OFS_HASH = 4'h1;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h2;
    localparam logic [3:0] OFS_IRQ_CLEAR = 4'h3;
    localparam logic [3:0] OFS_IRQ_ENABLE = 4'h4;
    localparam logic [3:0] OFS_TX_BYTES = 4'h5;
    // receive status word fields
    localparam int RX_LEN_LSB = 16;
    localparam int RX_LEN_MSB = 29;
    localparam int RX_MCAST_BIT = 10;
    localparam int RX_LONG_BIT = 7;
    localparam int RX_DRIBBLE_BIT = 2;
    localparam int RX_CRC_BIT = 1;
    localparam int RX_OVERRUN_BIT = 0;
    // transmit status word fields
    localparam int TX_CARLOSS_BIT = 11;
    localparam int TX_NOCAR_BIT = 10;
    localparam int TX_LATECOL_BIT = 9;
    localparam int TX_EXCOL_BIT = 8;
    localparam int TX_HBFAIL_BIT = 7;
    localparam int TX_COLCNT_LSB = 3;
    localparam int TX_COLCNT_MSB = 6;
    localparam int TX_DEFER_BIT = 0;
    // transmit control word fields
    localparam int TX_BUF1_LSB = 0;
    localparam int TX_BUF1_MSB = 10;
    localparam int TX_BUF2_LSB = 11;
    localparam int TX_BUF2_MSB = 21;
    // multicast hash
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam int HASH_BYTES = 6;
    localparam int HASH_BITS = 9;
    // reset values
    localparam logic [15:0] MISSED_RESET = 16'h0000;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    // interrupt status bit positions
    localparam int IRQ_RX_DONE = 0;
    localparam int IRQ_TX_DONE = 1;
    localparam int IRQ_SHORT = 2;

    typedef struct packed {
        logic [13:0] length;
        logic multicast;
        logic too_long;
        logic dribble;
        logic crc_error;
        logic overrun;
    } rx_result_s;

    typedef struct packed {
        logic carrier_lost;
        logic no_carrier;
        logic late_collision;
        logic excess_collisions;
        logic heartbeat_fail;
        logic [3:0] collisions;
        logic deferred;
    } tx_result_s;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef enum logic [2:0] {
        HASH_IDLE = 3'b001,
        HASH_RUN = 3'b010,
        HASH_DONE = 3'b100
    } hash_state_e;
endpackage

/* File: host_driver_model.sv */
// host driver model: tallies completed descriptors as a counting driver does
`timescale 1ns/10ps
module host_driver_model
    import mac_status_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic rx_status_valid,
    input wire logic [31:0] rx_status_word,
    input wire logic tx_status_valid,
    input wire logic [31:0] tx_status_word,
    output logic [31:0] rx_bytes,
    output logic [15:0] mcast_frames,
    output logic [15:0] short_circuits
);
    logic last_nocar;
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rx_bytes <= 32'h0;
            mcast_frames <= 16'h0;
            short_circuits <= 16'h0;
            last_nocar <= 1'b0;
        end
        else
        begin
            // only error-free frames count towards bytes received
            if (rx_status_valid && (rx_status_word & 32'h00000087) == 0)
            begin
                rx_bytes <= rx_bytes + {18'h0, rx_status_word[29:16]};
                if (rx_status_word[10])
                    mcast_frames <= mcast_frames + 16'h1;
            end
            if (tx_status_valid)
            begin
                if (last_nocar && tx_status_word[10])
                    short_circuits <= short_circuits + 16'h1;
                last_nocar <= tx_status_word[10];
            end
        end
    end
endmodule

/* File: tb_mac_frame_status_hash.sv */
// testbench for the frame status, missed counter and hash block
`timescale 1ns/10ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_count++; $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_mac_frame_status_hash;
    import mac_status_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rx_done = 1'b0;
    rx_result_s rx_result = '0;
    logic tx_done = 1'b0;
    tx_result_s tx_result = '0;
    logic [31:0] tx_control_word = 32'h0;
    logic rx_no_buffer = 1'b0;
    logic hash_start = 1'b0;
    logic [47:0] hash_addr = 48'h0;
    logic [31:0] reg_rdata, rx_status_word, tx_status_word, rx_bytes;
    logic rx_status_valid, tx_status_valid, hash_valid, irq;
    logic [8:0] hash_index;
    logic [15:0] mcast_frames, short_circuits;
    int err_count = 0;
    int compares = 0;
    int n;
    mac_frame_status_hash mac_frame_status_hash_i (.core_clk(core_clk),
        .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_done(rx_done), .rx_result(rx_result), .tx_done(tx_done),
        .tx_result(tx_result), .tx_control_word(tx_control_word),
        .rx_no_buffer(rx_no_buffer), .hash_start(hash_start),
        .hash_addr(hash_addr), .rx_status_valid(rx_status_valid),
        .rx_status_word(rx_status_word), .tx_status_valid(tx_status_valid),
        .tx_status_word(tx_status_word), .hash_valid(hash_valid),
        .hash_index(hash_index), .irq(irq));
    host_driver_model host_driver_model_i (.core_clk(core_clk),
        .reset(reset), .rx_status_valid(rx_status_valid),
        .rx_status_word(rx_status_word), .tx_status_valid(tx_status_valid),
        .tx_status_word(tx_status_word), .rx_bytes(rx_bytes),
        .mcast_frames(mcast_frames), .short_circuits(short_circuits));
    always #5 core_clk = ~core_clk;
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic rx_frame(input logic [18:0] r, input logic [31:0] exp);
        @(posedge core_clk);
        rx_done <= 1'b1;
        rx_result <= rx_result_s'(r);
        @(posedge core_clk);
        rx_done <= 1'b0;
        #1;
        `CHK(rx_status_valid, 1'b1)
        `CHK(rx_status_word, exp)
        @(posedge core_clk);
        #1;
        `CHK(rx_status_valid, 1'b0)
    endtask
    task automatic tx_frame(input logic [9:0] r, input logic [31:0] exp);
        @(posedge core_clk);
        tx_done <= 1'b1;
        tx_result <= tx_result_s'(r);
        tx_control_word <= 32'hFFC00FFF;
        @(posedge core_clk);
        tx_done <= 1'b0;
        #1;
        `CHK(tx_status_valid, 1'b1)
        `CHK(tx_status_word, exp)
        // let the host model take this descriptor before any tally check
        @(posedge core_clk);
        #1;
        `CHK(tx_status_valid, 1'b0)
    endtask
    // reference crc walk, bit by bit, lsb of byte 0 first
    function automatic logic [8:0] ref_hash(input logic [47:0] a);
        logic [31:0] c;
        logic [8:0] h;
        c = CRC_INIT;
        for (int i = 0; i < 48; i++)
            c = (c >> 1) ^ ((c[0] ^ a[i]) ? CRC_POLY : 32'h0);
        for (int k = 0; k < 9; k++)
            h[k] = c[31 - k];
        return h;
    endfunction
    task automatic run_hash(input logic [47:0] a);
        logic [31:0] d;
        @(posedge core_clk);
        hash_start <= 1'b1;
        hash_addr <= a;
        @(posedge core_clk);
        hash_start <= 1'b0;
        n = 0;
        do
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        while (hash_valid !== 1'b1 && n < 60);
        // valid is registered on the 49th edge after the start edge
        `CHK(n, 49)
        `CHK(hash_index, ref_hash(a))
        reg_read(OFS_HASH, d);
        `CHK(d, {23'h0, ref_hash(a)})
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    logic [9:0] tx_tab [4] = '{10'h003, 10'h29E, 10'h060, 10'h100};
    logic [31:0] tx_exp [4] = '{32'h9, 32'hA78, 32'h180, 32'h400};
    logic [31:0] d;
    initial
    begin
        #200000;
        err_count++;
        conclude();
    end
    initial
    begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        reg_read(OFS_MISSED, d);
        `CHK(d, 32'h0)
        reg_read(4'h6, d);
        `CHK(d, 32'h0)
        reg_write(OFS_IRQ_ENABLE, 32'h1);
        rx_frame(19'h0BDD0, 32'h05EE0400);
        `CHK(irq, 1'b1)
        rx_frame(19'h7FFEF, 32'h3FFF0087);
        rx_frame(19'h00802, 32'h00400002);
        `CHK(rx_bytes, 32'h5EE)
        `CHK(mcast_frames, 16'h1)
        reg_write(OFS_IRQ_CLEAR, 32'h1);
        @(posedge core_clk);
        #1;
        `CHK(irq, 1'b0)
        for (int i = 0; i < 4; i++)
            tx_frame(tx_tab[i], tx_exp[i]);
        tx_frame(10'h100, 32'h400);
        `CHK(short_circuits, 16'h1)
        `CHK(irq, 1'b0)
        reg_read(OFS_TX_BYTES, d);
        `CHK(d, 32'h800)
        reg_read(OFS_IRQ_STATUS, d);
        `CHK(d, 32'h6)
        reg_write(OFS_IRQ_ENABLE, 32'h4);
        @(posedge core_clk);
        #1;
        `CHK(irq, 1'b1)
        reg_write(OFS_IRQ_CLEAR, 32'h7);
        reg_read(OFS_IRQ_STATUS, d);
        `CHK(d, 32'h0)
        `CHK(irq, 1'b0)
        @(posedge core_clk);
        rx_no_buffer <= 1'b1;
        repeat (3) @(posedge core_clk);
        rx_no_buffer <= 1'b0;
        reg_write(OFS_MISSED, 32'hFFFF);
        reg_read(OFS_MISSED, d);
        `CHK(d, 32'h3)
        run_hash(48'hFFFFFFFFFFFF);
        run_hash(48'h0100005E0001);
        conclude();
    end
endmodule
